// ### common/flash_params.svh
// constants for the serial flash instruction block: opcodes, register
// offsets, identity values and self-timed delays at a 4 ns clock
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

// instruction opcodes
`define OP_DREAD 8'h3b
`define OP_MID 8'h90
`define OP_UID 8'h4b
`define OP_JID 8'h9f
`define OP_PD 8'hb9
`define OP_REL 8'hab
`define OP_PP 8'h02
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDST 8'h05

// wishbone register byte offsets
`define REG_CTRL 4'h0
`define REG_STAT 4'h4

// array size: 4 Mbit as 2^19 bytes
`define MEM_AW 19
`define MEM_BYTES 20'h80000

// identity values, all arbitrary
`define MFR_CODE 8'h5a
`define TYPE_CODE 8'h40
`define CAP_CODE 8'h13
`define DEV_CODE 8'h12
`define UID_VALUE 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210

// timing, in ns and in 4 ns cycles
`define CLK_NS 4
`define PD_NS 3000
`define PD_CYC 12'(`PD_NS / `CLK_NS)
`define RES1_NS 3000
`define RES1_CYC 12'((`RES1_NS + `CLK_NS - 1) / `CLK_NS)
`define RES2_NS 1800
`define RES2_CYC 12'((`RES2_NS + `CLK_NS - 1) / `CLK_NS)
`define PP_NS 900000
`define PP_CYC ((`PP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### common/flash_pkg.sv
// types for the serial flash instruction block
// assumes the constants header is included by the design file
package flash_pkg;

  // ==========================================================
  // instruction phase
  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b000,
    PH_HDR = 3'b001,
    PH_OUT = 3'b010,
    PH_DATA = 3'b011,
    PH_IGN = 3'b100
  } phase_e;

  // ==========================================================
  // pin and bus carriers
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic io0;
  } spi_in_s;

  typedef struct packed {
    logic io0_out;
    logic io0_oe;
    logic io1_out;
    logic io1_oe;
  } spi_out_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  // ==========================================================
  // module state apart from the page buffer and the array
  typedef struct packed {
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [1:0] io0_sync;
    phase_e phase;
    logic [7:0] op;
    logic [7:0] shin;
    logic [2:0] bitc;
    logic [8:0] bytec;
    logic [23:0] addr;
    logic [7:0] txsh;
    logic [2:0] txc;
    logic [7:0] oidx;
    logic write_enable_latch;
    logic busy_flag;
    logic [2:0] protect_bits;
    logic deep_sleep_state;
    logic [11:0] pd_cnt;
    logic [11:0] wake_cnt;
    logic [19:0] prog_cnt;
    logic [8:0] commit;
    logic pdata;
    logic [255:0] pmask;
    spi_out_s out;
    wb_rsp_s rsp;
  } state_s;

endpackage : flash_pkg

// ### verilog/flash_id_prog.sv
// serial flash slave: dual read, id reads, deep sleep, page program
// assumes spi mode 0 from a host; pins are synchronised to ref_clk,
// which must run well above four times the serial clock
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "flash_params.svh"

module flash_id_prog #(
  parameter logic [19:0] PROG_CYCLES = 20'(`PP_CYC)
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire flash_pkg::spi_in_s spi_in,
  output flash_pkg::spi_out_s spi_out,
  input wire flash_pkg::wb_req_s wb_req,
  output flash_pkg::wb_rsp_s wb_rsp
);

  // ==========================================================
  // helpers
  // bytes clocked in before output starts; zero for no readout
  function automatic logic [8:0] hdr_len(input logic [7:0] op);
    case (op)
      `OP_RDST, `OP_JID: hdr_len = 9'd1;
      `OP_MID, `OP_REL: hdr_len = 9'd4;
      `OP_DREAD, `OP_UID: hdr_len = 9'd5;
      default: hdr_len = 9'd0;
    endcase
  endfunction : hdr_len

  // protected area grows downward from the top of the array
  function automatic logic is_prot(input logic [2:0] bp, input logic [23:0] a);
    logic [19:0] lim;
    lim = `MEM_BYTES >> (3'd7 - bp);
    is_prot = (bp != 3'd0) && ({1'b0, a[18:0]} >= (`MEM_BYTES - lim));
  endfunction : is_prot

  flash_pkg::state_s s;
  flash_pkg::state_s n;
  logic [7:0] mem [0:(1 << `MEM_AW) - 1];
  logic [7:0] pbuf [0:255];
  logic [7:0] in_byte;
  logic [7:0] fresh;
  logic [7:0] ob;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_high;
  logic cs_rise;
  logic byte_done;
  logic accept;
  logic asleep;
  logic pbuf_we;
  logic mem_we;

  assign spi_out = s.out;
  assign wb_rsp = s.rsp;

  // ==========================================================
  // edge and level decode on the second and third sync stages
  assign sclk_rise = s.sclk_sync[1] & ~s.sclk_sync[2];
  assign sclk_fall = ~s.sclk_sync[1] & s.sclk_sync[2];
  assign cs_high = s.cs_sync[1];
  assign cs_rise = s.cs_sync[1] & ~s.cs_sync[2];
  assign in_byte = {s.shin[6:0], s.io0_sync[1]};
  assign byte_done = ~cs_high & sclk_rise & (s.bitc == 3'd7);
  assign asleep = s.deep_sleep_state | (s.pd_cnt != 12'd0);
  // commit one buffered byte per clock during the program cycle
  assign mem_we = s.busy_flag & ~s.commit[8] & s.pmask[s.commit[7:0]];

  // decoder gate on the opcode byte
  always_comb
  begin
    if (s.wake_cnt != 12'd0)
      accept = 1'b0; // still waking: select must stay high
    else if (in_byte == `OP_REL)
      accept = ~s.busy_flag;
    else
      // status stays readable while busy, nothing else gets through
      accept = ~asleep & (~s.busy_flag | (in_byte == `OP_RDST));
  end

  // readout byte for the current output position
  always_comb
  begin
    case (s.op)
      `OP_DREAD: fresh = mem[s.addr[`MEM_AW-1:0]];
      `OP_MID: fresh = (s.oidx[0] ^ s.addr[0]) ? `DEV_CODE : `MFR_CODE;
      `OP_UID: fresh = 8'(`UID_VALUE >> {~s.oidx[3:0], 3'b000});
      `OP_REL: fresh = `DEV_CODE; // repeats until select rises
      `OP_RDST: fresh = {3'b000, s.protect_bits, s.write_enable_latch, s.busy_flag};
      `OP_JID:
      begin
        case (s.oidx)
          8'h00: fresh = `MFR_CODE;
          8'h01: fresh = `TYPE_CODE;
          8'h02: fresh = `CAP_CODE;
          default: fresh = 8'h00;
        endcase
      end
      default: fresh = 8'h00;
    endcase
    ob = (s.txc == 3'd0) ? fresh : s.txsh;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    n = s;
    pbuf_we = 1'b0;
    n.sclk_sync = {s.sclk_sync[1:0], spi_in.sclk};
    n.cs_sync = {s.cs_sync[1:0], spi_in.cs_n};
    n.io0_sync = {s.io0_sync[0], spi_in.io0};

    // wishbone slave: one wait state, unmapped offsets read zero
    n.rsp.ack = wb_req.cyc & wb_req.stb & ~s.rsp.ack;
    n.rsp.dat = 32'h0000_0000;
    if (wb_req.cyc & wb_req.stb & ~s.rsp.ack)
    begin
      case (wb_req.adr)
        `REG_CTRL: n.rsp.dat = {29'h0, s.protect_bits};
        `REG_STAT: n.rsp.dat = {29'h0, s.deep_sleep_state, s.write_enable_latch, s.busy_flag};
        default: n.rsp.dat = 32'h0000_0000;
      endcase
    end
    // a write lands at the edge where the master sees ack high
    if (wb_req.cyc & wb_req.stb & s.rsp.ack & wb_req.we & wb_req.sel[0]
        & (wb_req.adr == `REG_CTRL))
      n.protect_bits = wb_req.dat[2:0];

    // power state timers
    if (s.pd_cnt != 12'd0)
    begin
      n.pd_cnt = s.pd_cnt - 12'd1;
      if (s.pd_cnt == 12'd1)
        n.deep_sleep_state = 1'b1;
    end
    if (s.wake_cnt != 12'd0)
    begin
      n.wake_cnt = s.wake_cnt - 12'd1;
      if (s.wake_cnt == 12'd1)
        n.deep_sleep_state = 1'b0;
    end

    // self-timed program cycle; needs PROG_CYCLES of at least 256 to commit all
    if (s.busy_flag)
    begin
      n.prog_cnt = s.prog_cnt - 20'd1;
      if (~s.commit[8])
        n.commit = s.commit + 9'd1;
      if (s.prog_cnt == 20'd1)
        n.busy_flag = 1'b0;
    end

    if (cs_high)
    begin
      // byte-boundary completion of write-type and power instructions
      if (cs_rise && (s.phase != flash_pkg::PH_IGN) && (s.phase != flash_pkg::PH_IDLE)
          && (s.bitc == 3'd0))
      begin
        case (s.op)
          `OP_WREN: if (s.bytec == 9'd1) n.write_enable_latch = 1'b1;
          `OP_WRDI: if (s.bytec == 9'd1) n.write_enable_latch = 1'b0;
          `OP_PD: if (s.bytec == 9'd1) n.pd_cnt = `PD_CYC;
          `OP_REL:
          begin
            if (s.deep_sleep_state && s.bytec == 9'd1)
              n.wake_cnt = `RES1_CYC;
            else if (s.deep_sleep_state && s.bytec >= 9'd4)
              n.wake_cnt = `RES2_CYC;
          end
          `OP_PP:
          begin
            // partial last byte falls through the bitc check
            if (s.pdata && s.write_enable_latch && !is_prot(s.protect_bits, s.addr))
            begin
              n.busy_flag = 1'b1;
              n.prog_cnt = PROG_CYCLES;
              n.commit = 9'd0;
              n.write_enable_latch = 1'b0; // cleared at start
            end
          end
          default: n.op = s.op;
        endcase
      end
      // deselected: back to standby, outputs released
      n.phase = flash_pkg::PH_IDLE;
      n.bitc = 3'd0;
      n.bytec = 9'd0;
      n.txc = 3'd0;
      n.oidx = 8'h00;
      n.out = '0;
    end
    else if (sclk_rise)
    begin
      // input bits are taken on the rising serial edge
      n.shin = in_byte;
      n.bitc = s.bitc + 3'd1;
      if (s.bitc == 3'd7)
      begin
        if (s.bytec != 9'h1ff)
          n.bytec = s.bytec + 9'd1;
        case (s.phase)
          flash_pkg::PH_IDLE:
          begin
            n.op = in_byte;
            if (!accept)
              n.phase = flash_pkg::PH_IGN;
            else if (hdr_len(in_byte) == 9'd1)
              n.phase = flash_pkg::PH_OUT;
            else
              n.phase = flash_pkg::PH_HDR;
            if (in_byte == `OP_PP)
            begin
              n.pmask = '0;
              n.pdata = 1'b0;
            end
          end
          flash_pkg::PH_HDR:
          begin
            if (s.bytec <= 9'd3)
              n.addr = {s.addr[15:0], in_byte};
            if ((hdr_len(s.op) != 9'd0) && (s.bytec + 9'd1 == hdr_len(s.op)))
              n.phase = flash_pkg::PH_OUT;
            else if ((s.op == `OP_PP) && (s.bytec == 9'd3))
              n.phase = flash_pkg::PH_DATA;
          end
          flash_pkg::PH_DATA:
          begin
            // later bytes overwrite earlier ones at the same offset
            pbuf_we = 1'b1;
            n.pmask[s.addr[7:0]] = 1'b1;
            n.addr[7:0] = s.addr[7:0] + 8'd1; // page wrap
            n.pdata = 1'b1;
          end
          default: n.phase = s.phase;
        endcase
      end
    end
    else if (sclk_fall && (s.phase == flash_pkg::PH_OUT))
    begin
      // output bits change on the falling serial edge
      n.out.io1_out = ob[7];
      n.out.io1_oe = 1'b1;
      if (s.txc == 3'd0 && s.op == `OP_DREAD)
        n.addr = s.addr + 24'd1;
      if (s.op == `OP_DREAD)
      begin
        n.out.io0_out = ob[6];
        n.out.io0_oe = 1'b1;
        n.txsh = {ob[5:0], 2'b00};
        n.txc = (s.txc == 3'd3) ? 3'd0 : s.txc + 3'd1;
        if (s.txc == 3'd3)
          n.oidx = s.oidx + 8'd1;
      end
      else
      begin
        n.txsh = {ob[6:0], 1'b0};
        n.txc = s.txc + 3'd1;
        if (s.txc == 3'd7)
          n.oidx = s.oidx + 8'd1;
      end
    end
  end

  // ==========================================================
  // registers; reset leaves the part awake
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= n;
  end

  // page buffer and array: too large for reset, contents start unknown
  always_ff @(posedge ref_clk)
  begin
    if (pbuf_we)
      pbuf[s.addr[7:0]] <= in_byte;
    if (mem_we)
      mem[{s.addr[`MEM_AW-1:8], s.commit[7:0]}] <= pbuf[s.commit[7:0]];
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_WEL_AT_PROGRAM: assert property ($rose(s.busy_flag) |-> !s.write_enable_latch && $past(s.write_enable_latch)) else $error("program started without enable latch");
  AST_PROG_HOLDS: assert property ($rose(s.busy_flag) |=> s.busy_flag [*8]) else $error("busy dropped early");
  AST_PROTECTED: assert property ($rose(s.busy_flag) |-> !is_prot(s.protect_bits, s.addr)) else $error("protected page programmed");
  AST_AWAKE_AFTER_RESET: assert property ($fell(rst) |-> !s.deep_sleep_state) else $error("asleep after reset");
  AST_SLEEP_ENTRY: assert property ($rose(s.deep_sleep_state) |-> $past(s.pd_cnt) == 12'd1) else $error("sleep entered without delay");
  AST_WAKE_DELAY: assert property ($fell(s.deep_sleep_state) |-> $past(s.wake_cnt) == 12'd1) else $error("woke without release delay");
  AST_ASLEEP_IGNORES: assert property (byte_done && s.phase == flash_pkg::PH_IDLE && s.deep_sleep_state && in_byte != `OP_REL |=> s.phase == flash_pkg::PH_IGN) else $error("instruction decoded while asleep");
  AST_BUSY_NO_JEDEC: assert property (byte_done && s.phase == flash_pkg::PH_IDLE && s.busy_flag && in_byte == `OP_JID && s.prog_cnt > 20'd2 |=> s.phase == flash_pkg::PH_IGN && s.busy_flag && ($past(s.prog_cnt) == s.prog_cnt + 20'd1)) else $error("jedec decoded while busy");
  AST_DESELECT_ENDS: assert property (cs_high |=> !s.out.io1_oe && s.phase == flash_pkg::PH_IDLE) else $error("output after deselect");
  AST_PAGE_WRAP: assert property (pbuf_we && s.addr[7:0] == 8'hff |=> s.addr[7:0] == 8'h00 && $stable(s.addr[23:8])) else $error("page address did not wrap");
  AST_DUAL_ONLY: assert property (s.out.io0_oe |-> s.op == `OP_DREAD) else $error("io0 driven outside dual read");

  CVR_PROGRAM: cover property ($rose(s.busy_flag));
  CVR_SLEEP: cover property ($rose(s.deep_sleep_state));
  CVR_WAKE: cover property ($fell(s.deep_sleep_state));
  CVR_DUAL: cover property (s.out.io0_oe && sclk_fall);

endmodule : flash_id_prog

// ### tb/spi_host_model.sv
// host side serial master: frames, byte transfers and dual reads
// assumes every task is entered right after a ref_clk rising edge
`timescale 1ns/1ps
module spi_host_model
(
  input wire logic ref_clk,
  input wire flash_pkg::spi_out_s so,
  output logic sclk,
  output logic cs_n,
  output wire logic io0,
  output int oe_cnt
);
  logic hv;
  logic hen;
  logic tog;

  // ==========================================================
  // line state
  // a released io0 toggles, so a stale bit never reads as valid
  assign io0 = so.io0_oe ? so.io0_out : (hen ? hv : tog);

  // idle bus at time zero: select high, clock low
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    hv = 1'b0;
    hen = 1'b1;
    tog = 1'b0;
    oe_cnt = 0;
  end

  // counts driven cycles so the bench can prove a frame was ignored
  always @(posedge ref_clk)
  begin
    tog <= ~tog;
    oe_cnt <= oe_cnt + int'(so.io1_oe | so.io0_oe);
  end

  // ==========================================================
  // frame tasks, half a serial period is 8 ref_clk cycles
  task automatic half;
    repeat (8) @(posedge ref_clk);
  endtask : half

  // select stays low from first to last bit of a frame
  task automatic start;
    cs_n <= 1'b0;
    half();
  endtask : start

  // select rises only with the clock low, at the byte count reached
  task automatic stop;
    half();
    cs_n <= 1'b1;
    hen <= 1'b1;
    half();
  endtask : stop

  // n bits msb first on io0; io1 read just before each rising edge
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      hv <= tx[i];
      half();
      rx[i] = so.io1_oe ? so.io1_out : tog;
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask : xfer

  // device owns io0 during dual data, so the host lets go of it
  task automatic dual(output logic [7:0] rx);
    hen <= 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      half();
      rx[2 * i + 1] = so.io1_oe ? so.io1_out : tog;
      rx[2 * i] = io0;
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask : dual
endmodule : spi_host_model

// ### tb/tb_flash_id_prog.sv
// self-checking bench for the serial flash instruction block
// assumes the host model from tb/ and the design's own assertions
`timescale 1ns/1ps
`include "flash_params.svh"
`define CHK(g, e) chk(64'(g), 64'(e))
module tb_flash_id_prog;
  localparam int PC = 4000;
  logic ref_clk;
  logic rst;
  logic sclk;
  logic cs_n;
  logic io0;
  int oe_cnt;
  int oe_was;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] q;
  logic [7:0] r;
  flash_pkg::wb_req_s wb_req;
  flash_pkg::wb_rsp_s wb_rsp;
  flash_pkg::spi_out_s spi_out;
  flash_pkg::spi_in_s spi_in;

  // ==========================================================
  // design and host
  assign spi_in = {sclk, cs_n, io0};
  flash_id_prog #(.PROG_CYCLES(20'(PC))) flash_id_prog_i
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .spi_in(spi_in),
    .spi_out(spi_out),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp)
  );
  spi_host_model spi_host_model_i
  (
    .ref_clk(ref_clk),
    .so(spi_out),
    .sclk(sclk),
    .cs_n(cs_n),
    .io0(io0),
    .oe_cnt(oe_cnt)
  );

  // 4 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // shared tasks
  task automatic end_of_test;
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // request stands until ack is seen at an edge; read data lands in q
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge ref_clk);
    if (n >= 50)
    begin
      num_errors++;
      end_of_test();
    end
  endtask : wb

  task automatic stat;
    wb(1'b0, `REG_STAT, 32'h0);
  endtask : stat

  // polls busy under a bound; program length here is PC clocks
  task automatic wait_idle;
    for (int i = 0; i < 2000; i++)
    begin
      stat();
      if (q[0] === 1'b0)
        return;
    end
    num_errors++;
    end_of_test();
  endtask : wait_idle

  task automatic go;
    spi_host_model_i.start();
  endtask : go

  task automatic fin;
    spi_host_model_i.stop();
  endtask : fin

  task automatic sb(input logic [7:0] b);
    spi_host_model_i.xfer(b, 8, r);
  endtask : sb

  task automatic cmd(input logic [7:0] op);
    go();
    sb(op);
    fin();
  endtask : cmd

  task automatic hdr(input logic [7:0] op, input logic [23:0] a);
    go();
    sb(op);
    sb(a[23:16]);
    sb(a[15:8]);
    sb(a[7:0]);
  endtask : hdr

  // ==========================================================
  // scenarios
  task automatic t_regs;
    stat();
    `CHK(q[2:0], 3'h0);
    wb(1'b1, `REG_CTRL, 32'h5);
    wb(1'b0, `REG_CTRL, 32'h0);
    `CHK(q[2:0], 3'h5);
    wb(1'b0, 4'h8, 32'h0);
    `CHK(q, 32'h0);
    wb(1'b1, `REG_CTRL, 32'h0);
  endtask : t_regs

  task automatic t_ids;
    logic [7:0] jid [3] = '{`MFR_CODE, `TYPE_CODE, `CAP_CODE};
    go();
    sb(`OP_JID);
    for (int i = 0; i < 3; i++)
    begin
      sb(8'h00);
      `CHK(r, jid[i]);
    end
    fin();
    `CHK(spi_out.io1_oe, 1'b0);
    for (int a = 0; a < 2; a++)
    begin
      hdr(`OP_MID, 24'(a));
      sb(8'h00);
      `CHK(r, a ? `DEV_CODE : `MFR_CODE);
      sb(8'h00);
      `CHK(r, a ? `MFR_CODE : `DEV_CODE);
      fin();
    end
    hdr(`OP_REL, 24'h0);
    for (int i = 0; i < 2; i++)
    begin
      sb(8'h00);
      `CHK(r, `DEV_CODE);
    end
    fin();
    hdr(`OP_UID, 24'h0);
    sb(8'h00);
    for (int i = 0; i < 16; i++)
    begin
      sb(8'h00);
      `CHK(r, 8'(`UID_VALUE >> (120 - 8 * i)));
    end
    fin();
  endtask : t_ids

  // program across the page end, then probe the busy window
  task automatic t_prog;
    logic [7:0] pd [3] = '{8'h3c, 8'hc5, 8'h96};
    cmd(`OP_WREN);
    stat();
    `CHK(q[1], 1'b1);
    hdr(`OP_PP, 24'h0000fe);
    for (int i = 0; i < 3; i++)
      sb(pd[i]);
    fin();
    stat();
    `CHK(q[1:0], 2'b01);
    oe_was = oe_cnt;
    go();
    sb(`OP_JID);
    sb(8'h00);
    fin();
    `CHK(oe_cnt, oe_was);
    hdr(`OP_REL, 24'h0);
    sb(8'h00);
    fin();
    `CHK(oe_cnt, oe_was);
    go();
    sb(`OP_RDST);
    sb(8'h00);
    `CHK(r, 8'h01);
    fin();
    wait_idle();
    `CHK(q[1:0], 2'b00);
    hdr(`OP_DREAD, 24'h0000fe);
    sb(8'h00);
    for (int i = 0; i < 2; i++)
    begin
      spi_host_model_i.dual(r);
      `CHK(r, pd[i]);
    end
    fin();
    hdr(`OP_DREAD, 24'h0);
    sb(8'h00);
    spi_host_model_i.dual(r);
    `CHK(r, pd[2]);
    fin();
  endtask : t_prog

  // protected page, then a frame cut three bits into a data byte
  task automatic t_reject;
    wb(1'b1, `REG_CTRL, 32'h7);
    cmd(`OP_WREN);
    hdr(`OP_PP, 24'h000200);
    sb(8'h77);
    fin();
    stat();
    `CHK(q[1:0], 2'b10);
    wb(1'b1, `REG_CTRL, 32'h0);
    hdr(`OP_PP, 24'h000300);
    sb(8'h11);
    spi_host_model_i.xfer(8'h22, 3, r);
    fin();
    stat();
    `CHK(q[1:0], 2'b10);
    cmd(`OP_WRDI);
  endtask : t_reject

  // only status and release frames are sent while asleep
  task automatic t_sleep;
    cmd(`OP_PD);
    repeat (600) @(posedge ref_clk);
    stat();
    `CHK(q[2], 1'b0);
    repeat (300) @(posedge ref_clk);
    stat();
    `CHK(q[2], 1'b1);
    oe_was = oe_cnt;
    go();
    sb(`OP_RDST);
    sb(8'h00);
    fin();
    `CHK(oe_cnt, oe_was);
    cmd(`OP_REL);
    repeat (600) @(posedge ref_clk);
    stat();
    `CHK(q[2], 1'b1);
    repeat (300) @(posedge ref_clk);
    stat();
    `CHK(q[2], 1'b0);
    cmd(`OP_PD);
    repeat (900) @(posedge ref_clk);
    hdr(`OP_REL, 24'h0);
    sb(8'h00);
    fin();
    repeat (500) @(posedge ref_clk);
    stat();
    `CHK(q[2], 1'b0);
  endtask : t_sleep

  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    wb_req = '0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    t_regs();
    t_ids();
    t_prog();
    t_reject();
    t_sleep();
    end_of_test();
  end
endmodule : tb_flash_id_prog
